/* File: pkg/timer_pkg.sv */
// Purpose: Shared constants and types for the reloadable 16-bit timer
// Assumes: Registers are 16 bits wide, reached by a 3-bit word address
// Notes:   Control layout is the ctrl_s struct, low bit first: en, mode, psel, pol, oe
package timer_pkg;

	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;
	localparam int PSEL_W = 3;
	localparam int PRE_W  = 7;
	localparam int CTRL_W = 8;
	localparam int ST_W   = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets (word index)
	localparam logic [ADDR_W-1:0] ADDR_CTRL   = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_COUNT  = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_RELOAD = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_MASK   = 3'h4;

	// Read-only bit of the control register: present output level
	localparam int CTRL_OUT_BIT = 8;

	// Status and mask bit positions
	localparam int ST_RELOAD = 0;
	localparam int ST_GATE   = 1;

	////////////////////////////////////////////////////////////////////////////////
	// Reset and restart values
	localparam logic [DATA_W-1:0] COUNT_RESET   = 16'h0000;
	localparam logic [DATA_W-1:0] COUNT_RESTART = 16'h0001;
	localparam logic [DATA_W-1:0] RELOAD_RESET  = 16'h0000;
	localparam logic [ST_W-1:0]   ST_RESET      = 2'h0;

	typedef enum logic [1:0] {
		MODE_ONESHOT = 2'h0,
		MODE_COMPARE = 2'h1,
		MODE_GATED   = 2'h2,
		MODE_RSVD    = 2'h3
	} mode_e;

	typedef struct packed {
		logic              oe;
		logic              input_polarity_bit;
		logic [PSEL_W-1:0] psel;
		mode_e             mode;
		logic              en;
	} ctrl_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_s;

endpackage

/* File: core/pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for a pin input
// Assumes: Pin changes no faster than a quarter of the clock rate
// Notes:   Level changes only once stages two and three agree
`timescale 1ns/1ps
module pin_sync (
	input  wire logic clk_sys,   // System clock
	input  wire logic reset_n,   // Synchronous reset, active low
	input  wire logic pin,       // Asynchronous pin
	output logic      level      // Filtered level
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_s;

	sync_s st_q;
	sync_s st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = pin;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// First stage feeds only the second
		if (st_q.s2 == st_q.s3) begin
			st_d.lvl = st_q.s3;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level = st_q.lvl;

endmodule

/* File: core/prescaler.sv */
// Purpose: Power-of-two prescaler, divide by 1 to 128
// Assumes: sel selects a divisor of two to the power sel
// Notes:   Count restarts from zero whenever run drops or clr pulses
`timescale 1ns/1ps
module prescaler #(
	parameter int SEL_W = timer_pkg::PSEL_W,
	parameter int CNT_W = timer_pkg::PRE_W
) (
	input  wire logic             clk_sys,  // System clock
	input  wire logic             reset_n,  // Synchronous reset, active low
	input  wire logic             run,      // Count enable
	input  wire logic             clr,      // Restart the division
	input  wire logic [SEL_W-1:0] sel,      // Divisor exponent
	output logic                  tick      // One cycle per period
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} pre_s;

	pre_s st_q;
	pre_s st_d;

	function automatic logic [CNT_W-1:0] last_count(input logic [SEL_W-1:0] s);
		logic [CNT_W:0] one_hot;
		one_hot = '0;
		one_hot[s] = 1'b1;
		return CNT_W'(one_hot - 1'b1);
	endfunction

	// Combinational so the counter sees it in the same cycle
	assign tick = run && (st_q.cnt == last_count(sel));

	always_comb begin
		st_d = st_q;
		if (!run || clr || tick) begin
			st_d.cnt = '0;
		end else begin
			st_d.cnt = st_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule

/* File: core/reload_timer.sv */
// Purpose: Reloadable 16-bit up-counting timer with prescaler and register port
// Assumes: Single 40 MHz clock; timer input pin is asynchronous
// Notes:   Modes one-shot, compare and gated; one level interrupt output
//
// How it works
// - Sixteen-bit up-counter with sixteen-bit reload register.
// - Prescaler in front of counter, divide by 1 up to 128.
// - Reload 0001 with prescale 1 gives the shortest timeout.
// - Reload 0000 spans the full count range, longest with prescale 128.
// - Counter wraps from FFFF to 0000 and keeps counting.
// - One-shot: on reload interrupt, count to 0001, clear enable, stop.
// - One-shot with output enabled: pin inverts for exactly one clock.
// - Compare mode always counts the prescaled system clock.
// - Gated: count only while input at level chosen by polarity bit.
// - Gated: interrupt on input deassertion and on reload.
// - Gated: on reload count to 0001, continue while input asserted.
// - Gated: written count serves first pass only, later passes from 0001.
// - Gated with output enabled: pin toggles on each reload.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module reload_timer #(
	parameter int DW = timer_pkg::DATA_W,
	parameter int AW = timer_pkg::ADDR_W
) (
	input  wire logic          CLK_SYS,     // System clock, 40 MHz
	input  wire logic          RESET_N,     // Synchronous reset, active low
	input  wire logic [AW-1:0] ADDR,        // Register word address
	input  wire logic [DW-1:0] WDATA,       // Write data
	input  wire logic          WR,          // Write strobe
	input  wire logic          RD,          // Read strobe
	output logic      [DW-1:0] RDATA,       // Read data, cycle after RD
	input  wire logic          TIMER_IN,    // Timer input pin
	output logic               TIMER_OUT,   // Timer output pin
	output logic               TIMER_OE,    // Output pin function enabled
	output logic               IRQ          // Level interrupt
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		timer_pkg::ctrl_s                ctrl;
		logic [DW-1:0]                   count;
		logic [DW-1:0]                   reload;
		logic [timer_pkg::ST_W-1:0]      status;
		logic [timer_pkg::ST_W-1:0]      mask;
		logic                            out_lvl;
		logic                            pulse;
		logic                            act_prev;
		logic [DW-1:0]                   rdata;
	} tmr_s;

	tmr_s                 st_q;
	tmr_s                 st_d;
	timer_pkg::bus_req_s  req;
	logic                 in_lvl;
	logic                 active;
	logic                 counting;
	logic                 tick;
	logic                 at_reload;
	logic                 ctrl_wr;

	function automatic logic hit(input logic [AW-1:0] a,
		input logic [AW-1:0] target, input logic strobe);
		return strobe && (a == target);
	endfunction

	assign req.addr  = ADDR;
	assign req.wdata = WDATA;
	assign req.wr    = WR;
	assign req.rd    = RD;

	////////////////////////////////////////////////////////////////////////////////
	// Input pin and prescaler

	// input rate
	// Filter relies on the pin staying put for several clocks
	pin_sync u_sync (
		.clk_sys (CLK_SYS),
		.reset_n (RESET_N),
		.pin     (TIMER_IN),
		.level   (in_lvl)
	);

	assign active = (in_lvl == st_q.ctrl.input_polarity_bit);

	always_comb begin
		counting = 1'b0;
		if (st_q.ctrl.en) begin
			unique case (st_q.ctrl.mode)
				timer_pkg::MODE_ONESHOT: counting = 1'b1;
				timer_pkg::MODE_COMPARE: counting = 1'b1;
				timer_pkg::MODE_GATED:   counting = active;
				timer_pkg::MODE_RSVD:    counting = 1'b0;
			endcase
		end
	end

	assign ctrl_wr = hit(req.addr, timer_pkg::ADDR_CTRL, req.wr);

	prescaler #(
		.SEL_W (timer_pkg::PSEL_W),
		.CNT_W (timer_pkg::PRE_W)
	) u_pre (
		.clk_sys (CLK_SYS),
		.reset_n (RESET_N),
		.run     (counting),
		.clr     (ctrl_wr),
		.sel     (st_q.ctrl.psel),
		.tick    (tick)
	);

	assign at_reload = tick && (st_q.count == st_q.reload);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [timer_pkg::ST_W-1:0] ev;
		logic [timer_pkg::ST_W-1:0] clr;
		ev  = '0;
		clr = '0;
		st_d          = st_q;
		st_d.pulse    = 1'b0;
		st_d.act_prev = active;

		if (tick) begin
			st_d.count = st_q.count + 1'b1;
		end

		if (at_reload) begin
			ev[timer_pkg::ST_RELOAD] = 1'b1;
			unique case (st_q.ctrl.mode)
				timer_pkg::MODE_ONESHOT: begin
					st_d.count   = timer_pkg::COUNT_RESTART;
					st_d.ctrl.en = 1'b0;
					st_d.pulse   = st_q.ctrl.oe;
				end
				timer_pkg::MODE_COMPARE: begin
					// Compare keeps counting past the match
					st_d.out_lvl = st_q.out_lvl ^ st_q.ctrl.oe;
				end
				timer_pkg::MODE_GATED: begin
					st_d.count   = timer_pkg::COUNT_RESTART;
					st_d.out_lvl = st_q.out_lvl ^ st_q.ctrl.oe;
				end
				timer_pkg::MODE_RSVD: begin
					st_d.count = st_q.count;
				end
			endcase
		end

		if (st_q.ctrl.en && (st_q.ctrl.mode == timer_pkg::MODE_GATED)
				&& st_q.act_prev && !active) begin
			ev[timer_pkg::ST_GATE] = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////////////
		// Register writes; software write beats counter update

		if (ctrl_wr) begin
			st_d.ctrl = timer_pkg::ctrl_s'(req.wdata[timer_pkg::CTRL_W-1:0]);
		end
		if (hit(req.addr, timer_pkg::ADDR_COUNT, req.wr)) begin
			st_d.count = req.wdata;
		end
		if (hit(req.addr, timer_pkg::ADDR_RELOAD, req.wr)) begin
			st_d.reload = req.wdata;
		end
		if (hit(req.addr, timer_pkg::ADDR_STATUS, req.wr)) begin
			clr = req.wdata[timer_pkg::ST_W-1:0];
		end
		if (hit(req.addr, timer_pkg::ADDR_MASK, req.wr)) begin
			st_d.mask = req.wdata[timer_pkg::ST_W-1:0];
		end

		// sticky events
		// A new event wins over a same-cycle clear
		st_d.status = (st_q.status & ~clr) | ev;

		////////////////////////////////////////////////////////////////////////////////
		// Read port

		st_d.rdata = '0;
		if (req.rd) begin
			unique case (req.addr)
				timer_pkg::ADDR_CTRL: begin
					st_d.rdata[timer_pkg::CTRL_W-1:0] = st_q.ctrl;
					st_d.rdata[timer_pkg::CTRL_OUT_BIT] = TIMER_OUT;
				end
				timer_pkg::ADDR_COUNT:  st_d.rdata = st_q.count;
				timer_pkg::ADDR_RELOAD: st_d.rdata = st_q.reload;
				timer_pkg::ADDR_STATUS: st_d.rdata[timer_pkg::ST_W-1:0] = st_q.status;
				timer_pkg::ADDR_MASK:   st_d.rdata[timer_pkg::ST_W-1:0] = st_q.mask;
				// Unmapped addresses read as zero
				default:                st_d.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			st_q.ctrl     <= '0;
			st_q.count    <= timer_pkg::COUNT_RESET;
			st_q.reload   <= timer_pkg::RELOAD_RESET;
			st_q.status   <= timer_pkg::ST_RESET;
			st_q.mask     <= timer_pkg::ST_RESET;
			st_q.out_lvl  <= 1'b0;
			st_q.pulse    <= 1'b0;
			st_q.act_prev <= 1'b0;
			st_q.rdata    <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign RDATA     = st_q.rdata;
	assign TIMER_OUT = st_q.out_lvl ^ st_q.pulse;
	assign TIMER_OE  = st_q.ctrl.oe;
	assign IRQ       = |(st_q.status & st_q.mask);

endmodule

/* File: dv/timer_pin_model.sv */
// Purpose: Far side of the timer input pin
// Assumes: Bench asks for a level; the model applies it when allowed
// Notes:   A late request waits, it is never dropped
`timescale 1ns/1ps
module timer_pin_model (
	input  wire logic clk_sys, // System clock
	input  wire logic want,    // Level asked for
	output logic      in_pin   // Timer input pin
);
	logic [1:0] hold_q = 2'h0;
	initial in_pin = 1'b0;
	////////////////////////////////////////////////////////////////////////////////
	// four clocks between changes
	always @(posedge clk_sys) begin
		if (hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end else if (want != in_pin) begin
			in_pin <= want;
			hold_q <= 2'h3;
		end
	end
endmodule

/* File: dv/reload_timer_checker.sv */
// Purpose: Port assertions for the reloadable timer
// Assumes: Mode and mask mirrored from bus writes
// Notes:   Mirror misses the one-shot auto clear, harmless for these checks
`timescale 1ns/1ps
module reload_timer_checker #(
	parameter int DW = timer_pkg::DATA_W,
	parameter int AW = timer_pkg::ADDR_W
) (
	input wire logic          CLK_SYS,   // System clock
	input wire logic          RESET_N,   // Reset, active low
	input wire logic [AW-1:0] ADDR,      // Word address
	input wire logic [DW-1:0] WDATA,     // Write data
	input wire logic          WR,        // Write strobe
	input wire logic          RD,        // Read strobe
	input wire logic [DW-1:0] RDATA,     // Read data
	input wire logic          TIMER_IN,  // Input pin
	input wire logic          TIMER_OUT, // Output pin
	input wire logic          TIMER_OE,  // Output enable
	input wire logic          IRQ        // Interrupt
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	logic [1:0] mode_q;
	logic [1:0] mask_q;
	wire        wr_ctrl = WR && ADDR == timer_pkg::ADDR_CTRL;
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			mode_q <= 2'h0;
			mask_q <= 2'h0;
		end else begin
			if (wr_ctrl) mode_q <= WDATA[2:1];
			if (WR && ADDR == timer_pkg::ADDR_MASK) mask_q <= WDATA[1:0];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == '0)
		else $error("read data not idle");
	a_reload_back: assert property (WR && ADDR == timer_pkg::ADDR_RELOAD ##1
		RD && ADDR == timer_pkg::ADDR_RELOAD |=> RDATA == $past(WDATA, 2))
		else $error("reload readback wrong");
	a_unmapped_zero: assert property (RD && ADDR > timer_pkg::ADDR_MASK |=> RDATA == '0)
		else $error("unmapped read not zero");
	a_reset_quiet: assert property ($rose(RESET_N) |-> !IRQ && !TIMER_OUT && !TIMER_OE)
		else $error("pins active after reset");
	a_oe_follow: assert property (wr_ctrl |=> TIMER_OE == $past(WDATA[7]))
		else $error("output enable wrong");
	a_oneshot_pulse: assert property (mode_q == 2'h0 && $rose(TIMER_OUT) |=> $fell(TIMER_OUT))
		else $error("one-shot pulse not one cycle");
	a_irq_masked: assert property (mask_q == 2'h0 ##1 mask_q == 2'h0 |-> !IRQ)
		else $error("interrupt while masked");
	a_stop_hold: assert property (wr_ctrl && !WDATA[0] ##1 !WR [*3] |-> $stable(TIMER_OUT))
		else $error("output moved while stopped");
endmodule
bind reload_timer reload_timer_checker #(.DW(DW), .AW(AW)) u_reload_timer_checker (
	.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .TIMER_IN(TIMER_IN), .TIMER_OUT(TIMER_OUT), .TIMER_OE(TIMER_OE), .IRQ(IRQ));

/* File: dv/reloadable_timer_16bit_bench.sv */
// Purpose: Self-checking bench for the reloadable timer
// Assumes: Output function enabled by every control write in these tests
// Notes:   Rows run one-shot timeouts; other modes follow by hand
`timescale 1ns/1ps
module reloadable_timer_16bit_bench;
	typedef struct {
		logic [2:0]  p;
		logic [15:0] r;
		logic [15:0] c;
		logic [15:0] n;
	} row_s;
	// Prescale exponent, reload, start count, edges until the pulse
	// Edges = ticks to the match, match tick included, times the divisor
	row_s rows [10] = '{'{3'h0, 16'h0001, 16'h0001, 16'h0001},
		'{3'h0, 16'h0002, 16'h0001, 16'h0002}, '{3'h1, 16'h0007, 16'h0007, 16'h0002},
		'{3'h2, 16'h0009, 16'h0008, 16'h0008}, '{3'h3, 16'h0005, 16'h0002, 16'h0020},
		'{3'h4, 16'h0004, 16'h0004, 16'h0010}, '{3'h5, 16'h0003, 16'h0003, 16'h0020},
		'{3'h6, 16'h0001, 16'h0001, 16'h0040}, '{3'h7, 16'h0003, 16'h0001, 16'h0180},
		'{3'h0, 16'h0000, 16'hfffe, 16'h0003}};
	logic        CLK_SYS = 1'b0;
	logic        RESET_N = 1'b0;
	logic        WR      = 1'b0;
	logic        RD      = 1'b0;
	logic        want    = 1'b0;
	logic [2:0]  ADDR    = 3'h0;
	logic [15:0] WDATA   = 16'h0;
	logic [15:0] RDATA;
	logic        TIMER_IN;
	logic        TIMER_OUT;
	logic        TIMER_OE;
	logic        IRQ;
	int          mismatches = 0;
	int          n_checks   = 0;
	int          cyc        = 0;
	always #12.5 CLK_SYS = ~CLK_SYS;
	reload_timer u_reload_timer (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TIMER_IN(TIMER_IN),
		.TIMER_OUT(TIMER_OUT), .TIMER_OE(TIMER_OE), .IRQ(IRQ));
	timer_pin_model u_timer_pin_model (.clk_sys(CLK_SYS), .want(want), .in_pin(TIMER_IN));
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge CLK_SYS);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge CLK_SYS);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask
	task automatic rchk(input string nm, input logic [2:0] a, input logic [15:0] e);
		logic [15:0] v;
		rd(a, v);
		check(nm, v, e);
	endtask
	// Edges until the output pin shows lvl, bounded
	task automatic wait_out(input logic lvl, output int k);
		k = 0;
		do begin
			@(posedge CLK_SYS);
			#1 k++;
		end while (TIMER_OUT !== lvl && k < 1000);
	endtask
	function automatic logic [15:0] ctl(input logic [2:0] p, input logic [1:0] m, input logic en);
		return {8'h0, 1'b1, 1'b1, p, m, en};
	endfunction
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int          k;
		logic [15:0] v;
		repeat (8) @(posedge CLK_SYS);
		RESET_N <= 1'b1;
		wr(timer_pkg::ADDR_MASK, 16'h0003);
		foreach (rows[i]) begin
			wr(timer_pkg::ADDR_COUNT, rows[i].c);
			wr(timer_pkg::ADDR_RELOAD, rows[i].r);
			wr(timer_pkg::ADDR_STATUS, 16'h0003);
			wr(timer_pkg::ADDR_CTRL, ctl(rows[i].p, 2'h0, 1'b1));
			wait_out(1'b1, k);
			check("timeout", k[15:0], rows[i].n);
			@(posedge CLK_SYS);
			#1 check("pins", {14'h0, TIMER_OE, TIMER_OUT}, 16'h0002);
			check("irq", {15'h0, IRQ}, 16'h0001);
			rchk("restart", timer_pkg::ADDR_COUNT, 16'h0001);
			rchk("stopped", timer_pkg::ADDR_CTRL, ctl(rows[i].p, 2'h0, 1'b0));
			rchk("held", timer_pkg::ADDR_COUNT, 16'h0001);
		end
		wr(timer_pkg::ADDR_MASK, 16'h0000);
		rchk("sticky", timer_pkg::ADDR_STATUS, 16'h0001);
		check("masked", {15'h0, IRQ}, 16'h0000);
		wr(timer_pkg::ADDR_STATUS, 16'h0001);
		rchk("cleared", timer_pkg::ADDR_STATUS, 16'h0000);
		// Compare with the pin idle: must count regardless
		wr(timer_pkg::ADDR_COUNT, 16'h0001);
		wr(timer_pkg::ADDR_RELOAD, 16'h0004);
		wr(timer_pkg::ADDR_CTRL, ctl(3'h0, 2'h1, 1'b1));
		wait_out(1'b1, k);
		check("compare", k[15:0], 16'h0004);
		repeat (3) @(posedge CLK_SYS);
		#1 check("level", {15'h0, TIMER_OUT}, 16'h0001);
		wr(timer_pkg::ADDR_CTRL, ctl(3'h0, 2'h1, 1'b0));
		rd(timer_pkg::ADDR_COUNT, v);
		rchk("hold", timer_pkg::ADDR_COUNT, v);
		wr(timer_pkg::ADDR_COUNT, 16'h0010);
		wr(timer_pkg::ADDR_RELOAD, 16'h0012);
		wr(timer_pkg::ADDR_STATUS, 16'h0003);
		wr(timer_pkg::ADDR_CTRL, ctl(3'h0, 2'h2, 1'b1));
		repeat (20) @(posedge CLK_SYS);
		rchk("gate shut", timer_pkg::ADDR_COUNT, 16'h0010);
		want <= 1'b1;
		wait_out(1'b0, k);
		wait_out(1'b1, k);
		check("pass", k[15:0], 16'h0012);
		want <= 1'b0;
		repeat (10) @(posedge CLK_SYS);
		rchk("events", timer_pkg::ADDR_STATUS, 16'h0003);
		// Second reset mid-run, then unmapped write and reset values
		@(posedge CLK_SYS);
		RESET_N <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		RESET_N <= 1'b1;
		wr(3'h5, 16'hffff);
		for (int a = 0; a < 8; a++) rchk("reset", a[2:0], 16'h0000);
		check("reset pins", {13'h0, TIMER_OUT, TIMER_OE, IRQ}, 16'h0000);
		// Reserved mode must not count
		wr(timer_pkg::ADDR_COUNT, 16'h0100);
		wr(timer_pkg::ADDR_CTRL, ctl(3'h0, 2'h3, 1'b1));
		repeat (8) @(posedge CLK_SYS);
		rchk("reserved", timer_pkg::ADDR_COUNT, 16'h0100);
		// Gated, polarity low, pin low: gate opens at once, one tick before the read
		wr(timer_pkg::ADDR_CTRL, 16'h0085);
		rchk("low gate", timer_pkg::ADDR_COUNT, 16'h0101);
		@(posedge CLK_SYS);
		ADDR <= timer_pkg::ADDR_RELOAD;
		WDATA <= 16'h5a3c;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		#1 check("reload", RDATA, 16'h5a3c);
		print_verdict();
	end
endmodule
